// ==== logic/dsp_mult_pkg.sv ====
// Purpose: shared constants and types of the multiplier stage
// Assumes: 32-bit register port, byte addresses
// Notes: offsets and field positions are used by the top and its tests

package dsp_mult_pkg;

   // ****************************************
   // geometry
   // ****************************************
   localparam int NUM_LANES = 8;
   localparam int LANE_BITS = 9;
   localparam int BANK_W = 72;
   localparam int PROD_W = 144;
   localparam int CHAIN_W = 18;

   typedef enum logic [1:0] {
      MODE_9X9 = 2'b00,
      MODE_18X18 = 2'b01,
      MODE_36X36 = 2'b10
   } mode_t;

   typedef logic [5:0] ctl_sel_t;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SEL = 8'h20;

   localparam int CFG_MODE = 0;
   localparam int CFG_INREG_A = 2;
   localparam int CFG_INREG_B = 3;
   localparam int CFG_SHIFT = 4;
   localparam int CFG_SIGN_REG = 5;
   localparam int CFG_PIPE = 6;
   localparam int CFG_SHARED = 7;
   localparam int CFG_CHAIN = 8;
   localparam int CFG_PSEL = 16;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;

   localparam int STS_REFUSED = 0;
   localparam int STS_MASKED = 1;
   localparam int STS_MODE = 2;

   localparam int SEL_A = 0;
   localparam int SEL_B = 8;
   localparam int SL_CLK = 0;
   localparam int SL_CLR = 2;
   localparam int SL_ENA = 4;

endpackage

// ==== logic/dsp_ctl_if.sv ====
// Purpose: block-wide register control lines
// Assumes: tick, clear and enable are synchronous to i_clk_sys
// Notes: clear acts asynchronously on the registers

`timescale 1ns/1ns
`default_nettype none

interface dsp_ctl_if;
   logic [3:0] tick;
   logic [3:0] aclr;
   logic [3:0] ena;

   modport drive (output tick, output aclr, output ena);
   modport take (input tick, input aclr, input ena);
endinterface

`default_nettype wire

// ==== logic/dsp_opnd_reg.sv ====
// Purpose: one register with selectable tick, clear and enable
// Assumes: selections are stable while data flows
// Notes: a selected clear zeroes the register at once

`timescale 1ns/1ns
`default_nettype none

module dsp_opnd_reg #(
   parameter int W = 9
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   dsp_ctl_if.take ctl,
   input wire dsp_mult_pkg::ctl_sel_t i_sel,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   import dsp_mult_pkg::*;

   if (W < 1) begin : g_bad_w
      $error("register width must be positive");
   end

   // ****************************************
   // control selection
   // ****************************************
   wire logic clr = i_rst || ctl.aclr[i_sel[SL_CLR+:2]];
   wire logic load = ctl.tick[i_sel[SL_CLK+:2]] && ctl.ena[i_sel[SL_ENA+:2]];

   always_ff @(posedge i_clk_sys or posedge clr) begin
      if (clr) begin
         o_q <= '0;
      end else if (load) begin
         o_q <= i_d;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_clear_zeroes: assert property (
      @(posedge i_clk_sys) disable iff (i_rst) clr |-> o_q == '0)
      else $error("selected clear did not zero the register");

   a_load_takes: assert property (
      @(posedge i_clk_sys) disable iff (i_rst)
      (load && !clr) |=> (o_q == $past(i_d)) || clr)
      else $error("register missed a selected load");

   a_hold_idle: assert property (
      @(posedge i_clk_sys) disable iff (i_rst)
      (!load && !clr) |=> $stable(o_q) || clr)
      else $error("register changed without a load");

endmodule // dsp_opnd_reg

`default_nettype wire

// ==== logic/dsp_multiplier_block.sv ====
// Purpose: configurable multiplier stage with operand and pipeline registers
// Assumes: all inputs synchronous to i_clk_sys; one configuration at a time
// Notes: products leave through a register every clock
//
// What this block does
// - one of 8x9, 4x18, 1x36 configurations
// - full 36x36 for matched signs
// - mixed signs: unsigned operand limited to 35 bits
// - separate signs 36x35 if they differ, shared sign 36x36
// - eight, four or one multipliers by width
// - optional operand registers loaded from routing
// - each operand, sign and pipeline register picks clock, clear, enable
// - shift mode drives per-operand chain outputs
// - chain may end at any multiplier
// - no operand shift chain in 36x36
// - sign high means signed, low unsigned
// - product unsigned only if both unsigned
// - products are full precision
// - sign controls unregistered or registered once
// - optional post multiply pipeline register
// - products pass onward through the output register
// - 36x36 built from four 18x18 parts
//
// Local design decisions: the plain strobed port and the placing of the registers.

`timescale 1ns/1ns
`default_nettype none

module dsp_multiplier_block #(
   parameter int LANES = 8,
   parameter int LANE_W = 9
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic [3:0] i_clk_tick,
   input wire logic [3:0] i_aclr,
   input wire logic [3:0] i_ena,
   input wire logic [dsp_mult_pkg::BANK_W-1:0] i_data_a,
   input wire logic [dsp_mult_pkg::BANK_W-1:0] i_data_b,
   input wire logic i_sign_a,
   input wire logic i_sign_b,
   input wire logic [dsp_mult_pkg::CHAIN_W-1:0] i_chain_in_first_operand,
   input wire logic [dsp_mult_pkg::CHAIN_W-1:0] i_chain_in_second_operand,
   output logic [dsp_mult_pkg::CHAIN_W-1:0] o_chain_out_first_operand,
   output logic [dsp_mult_pkg::CHAIN_W-1:0] o_chain_out_second_operand,
   output logic [dsp_mult_pkg::PROD_W-1:0] o_product,
   output logic o_product_signed
);
   import dsp_mult_pkg::*;

   if (LANES != NUM_LANES || LANE_W != LANE_BITS) begin : g_bad_cfg
      $error("only 8 lanes of 9 bits are supported");
   end

   // ****************************************
   // register port
   // ****************************************
   logic [31:0] cfg_r;
   logic masked_r;
   logic [13:0] sel_r [LANES];

   wire logic cfg_wr = i_wr && i_addr == OFS_CFG;
   wire logic sts_wr = i_wr && i_addr == OFS_STATUS;
   wire logic sel_hit = i_addr[7:5] == OFS_SEL[7:5] && i_addr[1:0] == 2'b00;
   wire logic [2:0] sel_idx = i_addr[4:2];

   wire logic m36 = cfg_r[CFG_MODE+:2] == MODE_36X36;
   wire logic m18 = cfg_r[CFG_MODE+:2] == MODE_18X18;
   wire logic m9 = !m36 && !m18;
   wire logic shift_act = cfg_r[CFG_SHIFT] && !m36;
   wire logic [3:0] chain_len = cfg_r[CFG_CHAIN+:4];

   logic masked_hit;
   wire logic masked_nxt = masked_hit || (masked_r && !(sts_wr && i_wdata[STS_MASKED]));

   wire logic [31:0] sts_v = {28'h0, cfg_r[CFG_MODE+:2], masked_r,
                              cfg_r[CFG_SHIFT] && m36};

   wire logic [31:0] rdata_nxt = (i_addr == OFS_CFG) ? cfg_r :
                                 (i_addr == OFS_STATUS) ? sts_v :
                                 sel_hit ? {18'h0, sel_r[sel_idx]} : 32'h0;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cfg_r <= CFG_RST;
         masked_r <= 1'b0;
         o_rdata <= 32'h0;
      end else begin
         if (cfg_wr) begin
            cfg_r <= i_wdata;
         end
         masked_r <= masked_nxt;
         o_rdata <= i_rd ? rdata_nxt : 32'h0;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < LANES; i++) begin
            sel_r[i] <= 14'h0;
         end
      end else if (i_wr && sel_hit) begin
         sel_r[sel_idx] <= i_wdata[13:0];
      end
   end

   // ****************************************
   // operand registers and shift chain
   // ****************************************
   dsp_ctl_if ctl ();
   assign ctl.tick = i_clk_tick;
   assign ctl.aclr = i_aclr;
   assign ctl.ena = i_ena;

   logic [BANK_W-1:0] qa_v;
   logic [BANK_W-1:0] qb_v;
   logic [BANK_W-1:0] da_v;
   logic [BANK_W-1:0] db_v;

   // chain enters at lane 0 and moves one multiplier per load
   wire logic [BANK_W-1:0] sha = m18 ?
      {qa_v[BANK_W-2*LANE_W-1:0], i_chain_in_first_operand} :
      {qa_v[BANK_W-LANE_W-1:0], i_chain_in_first_operand[CHAIN_W-1:LANE_W]};
   wire logic [BANK_W-1:0] shb = m18 ?
      {qb_v[BANK_W-2*LANE_W-1:0], i_chain_in_second_operand} :
      {qb_v[BANK_W-LANE_W-1:0], i_chain_in_second_operand[CHAIN_W-1:LANE_W]};

   for (genvar i = 0; i < LANES; i++) begin : g_lane
      wire logic [3:0] pos = m18 ? 4'(i / 2) : 4'(i);
      wire logic link = shift_act && pos < chain_len;

      assign da_v[i*LANE_W+:LANE_W] = link ? sha[i*LANE_W+:LANE_W] :
                                             i_data_a[i*LANE_W+:LANE_W];
      assign db_v[i*LANE_W+:LANE_W] = link ? shb[i*LANE_W+:LANE_W] :
                                             i_data_b[i*LANE_W+:LANE_W];

      dsp_opnd_reg #(.W(LANE_W)) u_ra (
         .i_clk_sys(i_clk_sys),
         .i_rst(i_rst),
         .ctl(ctl),
         .i_sel(sel_r[i][SEL_A+:6]),
         .i_d(da_v[i*LANE_W+:LANE_W]),
         .o_q(qa_v[i*LANE_W+:LANE_W])
      );

      dsp_opnd_reg #(.W(LANE_W)) u_rb (
         .i_clk_sys(i_clk_sys),
         .i_rst(i_rst),
         .ctl(ctl),
         .i_sel(sel_r[i][SEL_B+:6]),
         .i_d(db_v[i*LANE_W+:LANE_W]),
         .o_q(qb_v[i*LANE_W+:LANE_W])
      );
   end

   assign o_chain_out_first_operand = qa_v[BANK_W-1:BANK_W-CHAIN_W];
   assign o_chain_out_second_operand = qb_v[BANK_W-1:BANK_W-CHAIN_W];

   // shift mode always works through the registers
   wire logic [BANK_W-1:0] ma_v = (cfg_r[CFG_INREG_A] || shift_act) ? qa_v : i_data_a;
   wire logic [BANK_W-1:0] mb_v = (cfg_r[CFG_INREG_B] || shift_act) ? qb_v : i_data_b;

   // ****************************************
   // sign controls
   // ****************************************
   logic [1:0] sgn_q;

   dsp_opnd_reg #(.W(2)) u_rsgn (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .ctl(ctl),
      .i_sel(cfg_r[CFG_PSEL+:6]),
      .i_d({i_sign_b, i_sign_a}),
      .o_q(sgn_q)
   );

   wire logic [1:0] sgn = cfg_r[CFG_SIGN_REG] ? sgn_q : {i_sign_b, i_sign_a};
   wire logic sa = sgn[0];
   wire logic sb = cfg_r[CFG_SHARED] ? sgn[0] : sgn[1];

   // a shared sign never differs, so it keeps the full 36 bits
   wire logic mask_a = m36 && !sa && sb;
   wire logic mask_b = m36 && sa && !sb;
   wire logic [35:0] a36 = {ma_v[35] && !mask_a, ma_v[34:0]};
   wire logic [35:0] b36 = {mb_v[35] && !mask_b, mb_v[34:0]};
   assign masked_hit = (mask_a && ma_v[35]) || (mask_b && mb_v[35]);

   // ****************************************
   // multipliers
   // ****************************************
   function automatic logic [35:0] mul18(input logic [17:0] a, input logic sa_i,
                                         input logic [17:0] b, input logic sb_i);
      logic signed [18:0] ea;
      logic signed [18:0] eb;
      logic signed [37:0] p;
      ea = {sa_i && a[17], a};
      eb = {sb_i && b[17], b};
      p = ea * eb;
      return p[35:0];
   endfunction

   function automatic logic [17:0] ext9(input logic [8:0] x, input logic s);
      return {{9{s && x[8]}}, x};
   endfunction

   logic [PROD_W-1:0] st9;
   logic [PROD_W-1:0] st18;

   for (genvar k = 0; k < LANES; k++) begin : g_m9
      wire logic [35:0] p = mul18(ext9(ma_v[k*LANE_W+:LANE_W], sa), sa,
                                  ext9(mb_v[k*LANE_W+:LANE_W], sb), sb);
      assign st9[k*18+:18] = p[17:0];
   end

   // in 36x36 the four units take lo*lo, hi*lo, lo*hi, hi*hi
   for (genvar k = 0; k < 4; k++) begin : g_m18
      wire logic [17:0] ax = m36 ? a36[(k % 2)*18+:18] : ma_v[k*18+:18];
      wire logic [17:0] bx = m36 ? b36[(k / 2)*18+:18] : mb_v[k*18+:18];
      wire logic sax = m36 ? ((k % 2 == 1) && sa) : sa;
      wire logic sbx = m36 ? ((k / 2 == 1) && sb) : sb;
      assign st18[k*36+:36] = mul18(ax, sax, bx, sbx);
   end

   // ****************************************
   // pipeline register and 36-bit combine
   // ****************************************
   wire logic [PROD_W+1:0] st_v = {sb, sa, m9 ? st9 : st18};
   logic [PROD_W+1:0] pq;

   dsp_opnd_reg #(.W(PROD_W+2)) u_rpipe (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .ctl(ctl),
      .i_sel(cfg_r[CFG_PSEL+:6]),
      .i_d(st_v),
      .o_q(pq)
   );

   wire logic [PROD_W+1:0] pv = cfg_r[CFG_PIPE] ? pq : st_v;
   wire logic psa = pv[PROD_W];
   wire logic psb = pv[PROD_W+1];

   wire logic [71:0] x0 = {36'h0, pv[35:0]};
   wire logic [71:0] x1 = {{18{psa && pv[71]}}, pv[71:36], 18'h0};
   wire logic [71:0] x2 = {{18{psb && pv[107]}}, pv[107:72], 18'h0};
   wire logic [71:0] x3 = {pv[143:108], 36'h0};
   wire logic [71:0] sum36 = x0 + x1 + x2 + x3;
   wire logic [PROD_W-1:0] prod_nxt = m36 ? {72'h0, sum36} : pv[PROD_W-1:0];

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_product <= '0;
         o_product_signed <= 1'b0;
      end else begin
         o_product <= prod_nxt;
         o_product_signed <= psa || psb;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   wire logic [8:0] h_a0 = ma_v[8:0];
   wire logic [8:0] h_b0 = mb_v[8:0];
   wire logic [8:0] h_cin = i_chain_in_first_operand[CHAIN_W-1:LANE_W];
   // reference products, widened before the multiply so no bit is lost
   wire logic [17:0] h_p9 = h_a0 * h_b0;
   wire logic [71:0] h_pu = {36'h0, a36} * {36'h0, b36};
   wire logic signed [71:0] h_pss = $signed(a36) * $signed(b36);
   wire logic [5:0] h_ps = cfg_r[CFG_PSEL+:6];
   wire logic h_pload = ctl.tick[h_ps[SL_CLK+:2]] && ctl.ena[h_ps[SL_ENA+:2]] &&
                        !ctl.aclr[h_ps[SL_CLR+:2]];
   wire logic h_ld0 = ctl.tick[sel_r[0][SL_CLK+:2]] && ctl.ena[sel_r[0][SL_ENA+:2]] &&
                      !ctl.aclr[sel_r[0][SL_CLR+:2]];

   sequence s_m36_uu;
      m36 && !cfg_r[CFG_PIPE] && !sa && !sb;
   endsequence

   sequence s_pipe_load;
      m36 && cfg_r[CFG_PIPE] && h_pload && !sa && !sb ##1 m36 && cfg_r[CFG_PIPE];
   endsequence

   a_shift_blocked: assert property (
      m36 |-> !shift_act)
      else $error("shift chain active in 36x36 mode");

   a_lane9_product: assert property (
      (m9 && !cfg_r[CFG_PIPE] && !sa && !sb) |=>
      o_product[17:0] == $past(h_p9))
      else $error("9x9 lane product wrong");

   a_mult36_plain: assert property (
      s_m36_uu |=> o_product[71:0] == $past(h_pu))
      else $error("36x36 unsigned product wrong");

   a_mult36_signed: assert property (
      (m36 && !cfg_r[CFG_PIPE] && sa && sb) |=>
      o_product[71:0] == $past(h_pss))
      else $error("36x36 signed product wrong");

   a_pipe_latency: assert property (
      s_pipe_load |=> o_product[71:0] == $past(h_pu, 2))
      else $error("pipelined 36x36 product late or wrong");

   a_unsigned_flag: assert property (
      (!sa && !sb && !cfg_r[CFG_PIPE]) |=> !o_product_signed)
      else $error("unsigned product marked signed");

   a_signed_flag: assert property (
      ((sa || sb) && !cfg_r[CFG_PIPE]) |=> o_product_signed)
      else $error("signed product marked unsigned");

   a_msb_masked: assert property (
      (mask_a |-> !a36[35]) and (mask_b |-> !b36[35]))
      else $error("unsigned operand not cut to 35 bits");

   a_mask_sticky: assert property (
      masked_hit |=> masked_r)
      else $error("masked-bit flag lost");

   a_chain_entry: assert property (
      (m9 && shift_act && chain_len != 4'h0 && h_ld0) |=>
      qa_v[8:0] == $past(h_cin))
      else $error("chain input not taken by lane 0");

endmodule // dsp_multiplier_block

`default_nettype wire

// ==== verif/fabric_model.sv ====
// Purpose: model of the routing fabric that feeds the multiplier stage
// Assumes: tasks are called just after a rising clock edge
// Notes: the tasks move every output by non-blocking assignment

`timescale 1ns/1ns
`default_nettype none

module fabric_model (
   output logic [dsp_mult_pkg::BANK_W-1:0] o_data_a,
   output logic [dsp_mult_pkg::BANK_W-1:0] o_data_b,
   output logic o_sign_a,
   output logic o_sign_b,
   output logic [3:0] o_tick,
   output logic [3:0] o_aclr,
   output logic [3:0] o_ena,
   output logic [dsp_mult_pkg::CHAIN_W-1:0] o_chain_a,
   output logic [dsp_mult_pkg::CHAIN_W-1:0] o_chain_b
);
   import dsp_mult_pkg::*;

   initial begin
      {o_data_a, o_data_b, o_sign_a, o_sign_b, o_tick, o_aclr, o_ena, o_chain_a, o_chain_b} = '0;
   end

   task automatic set_ops(input logic [71:0] a, input logic [71:0] b, input logic sa,
                          input logic sb);
      o_data_a <= a;
      o_data_b <= b;
      o_sign_a <= sa;
      o_sign_b <= sb;
   endtask

   task automatic set_ctl(input logic [3:0] t, input logic [3:0] c, input logic [3:0] e);
      o_tick <= t;
      o_aclr <= c;
      o_ena <= e;
   endtask

   task automatic set_chain(input logic [17:0] a, input logic [17:0] b);
      o_chain_a <= a;
      o_chain_b <= b;
   endtask
endmodule // fabric_model

`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench of the multiplier stage
// Assumes: fabric model drives operands and controls
// Notes: expectations are computed from operand values and signs

`timescale 1ns/1ns
`default_nettype none

module tb;
   import dsp_mult_pkg::*;

   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [71:0] da, db;
   logic sa_w, sb_w;
   logic [3:0] tick, aclr, ena;
   logic [17:0] cia, cib, coa, cob;
   logic [143:0] prod, last_e;
   logic psg;
   int error_cnt = 0;
   int n_compared = 0;
   localparam logic [71:0] VA = 72'hff_ffe0_0f1c_3a55_aa01;
   localparam logic [71:0] VB = 72'h80_7fff_0001_ff00_8123;

   always #5 clk_sys = ~clk_sys;

   fabric_model fab (.o_data_a(da), .o_data_b(db), .o_sign_a(sa_w), .o_sign_b(sb_w),
      .o_tick(tick), .o_aclr(aclr), .o_ena(ena), .o_chain_a(cia), .o_chain_b(cib));

   dsp_multiplier_block dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_clk_tick(tick),
      .i_aclr(aclr), .i_ena(ena), .i_data_a(da), .i_data_b(db), .i_sign_a(sa_w),
      .i_sign_b(sb_w), .i_chain_in_first_operand(cia), .i_chain_in_second_operand(cib),
      .o_chain_out_first_operand(coa), .o_chain_out_second_operand(cob),
      .o_product(prod), .o_product_signed(psg));

   // ****************************************
   // checks and bus access
   // ****************************************
   task automatic wrap_up();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_prod(input logic [143:0] got, input logic [143:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      chk_word(rdata, exp);
   endtask

   function automatic logic [71:0] mulx(input logic [71:0] a, input logic [71:0] b,
                                         input logic sa, input logic sb, input int w);
      logic [71:0] m, xa, xb;
      m = {72{1'b1}} >> (72 - w);
      xa = a & m;
      xb = b & m;
      if (sa && xa[w-1]) xa = xa | ~m;
      if (sb && xb[w-1]) xb = xb | ~m;
      return (xa * xb) & ({72{1'b1}} >> (72 - 2 * w));
   endfunction

   // unsigned operand loses bit 35 when signs differ in 36x36
   function automatic logic [143:0] exp_of(input int w, input logic [71:0] a,
                                           input logic [71:0] b, input logic sa, input logic sb);
      logic [143:0] e;
      logic [71:0] ea, eb;
      int n;
      ea = a;
      eb = b;
      if (w == 36 && !sa && sb) ea[35] = 1'b0;
      if (w == 36 && sa && !sb) eb[35] = 1'b0;
      n = (w == 36) ? 1 : 72 / w;
      e = '0;
      for (int k = 0; k < n; k++) begin
         e = e | ({72'h0, mulx(ea >> (w * k), eb >> (w * k), sa, sb, w)} << (2 * w * k));
      end
      return e;
   endfunction

   task automatic op_check(input int w, input logic [71:0] a, input logic [71:0] b,
                           input logic sa, input logic sb, input logic shr, input int lat);
      logic esb;
      logic [143:0] e;
      esb = shr ? sa : sb;
      e = exp_of(w, a, b, sa, esb);
      @(posedge clk_sys);
      fab.set_ops(a, b, sa, sb);
      @(posedge clk_sys);
      #1;
      if (lat > 1) chk_prod(prod, last_e);
      repeat (lat - 1) @(posedge clk_sys);
      #1;
      chk_prod(prod, e);
      chk_word({31'h0, psg}, {31'h0, sa | esb});
      last_e = e;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      wrap_up();
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rd_reg(OFS_CFG, CFG_RST);
      rd_reg(OFS_STATUS, 32'h0);
      wr_reg(8'h40, 32'hffff_ffff);
      rd_reg(8'h40, 32'h0);
      chk_prod(prod, '0);
      @(posedge clk_sys);
      fab.set_ctl(4'hf, 4'h0, 4'hf);
      for (int s = 0; s < 4; s++) begin
         op_check(9, VA, VB, s[1], s[0], 1'b0, 1);
      end
      wr_reg(OFS_CFG, 32'h1);
      rd_reg(OFS_CFG, 32'h1);
      op_check(18, VA, VB, 1'b1, 1'b1, 1'b0, 1);
      wr_reg(OFS_CFG, 32'h41);
      op_check(18, VB, VA, 1'b0, 1'b1, 1'b0, 2);
      wr_reg(OFS_CFG, 32'h2d);
      op_check(18, VA, VA, 1'b1, 1'b0, 1'b0, 2);
      for (int k = 0; k < 8; k++) wr_reg(OFS_SEL + 8'(4 * k), 32'h1010);
      @(posedge clk_sys);
      fab.set_ctl(4'hf, 4'h0, 4'h1);
      fab.set_ops(VB, VB, 1'b1, 1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk_prod(prod, last_e);
      fab.set_ctl(4'hf, 4'h0, 4'h2);
      repeat (2) @(posedge clk_sys);
      #1;
      chk_prod(prod, exp_of(18, VB, VB, 1'b1, 1'b0));
      fab.set_ctl(4'hf, 4'h1, 4'h3);
      @(posedge clk_sys);
      #1;
      chk_prod(prod, '0);
      fab.set_ctl(4'hf, 4'h0, 4'h3);
      wr_reg(OFS_CFG, 32'h2d);
      @(posedge clk_sys);
      fab.set_ops(VA, VB, 1'b1, 1'b1);
      @(posedge clk_sys);
      fab.set_ops(VA, VB, 1'b0, 1'b0);
      @(posedge clk_sys);
      #1;
      chk_prod(prod, exp_of(18, VA, VB, 1'b1, 1'b1));
      wr_reg(OFS_CFG, 32'h2);
      op_check(36, {36'h0, 36'hf_ffff_ffff}, {36'h0, 36'hf_ffff_ffff}, 0, 0, 0, 1);
      op_check(36, {36'h0, 36'h8_0000_0001}, {36'h0, 36'h8_0000_0003}, 1, 1, 0, 1);
      op_check(36, {36'h0, 36'h8_0000_0005}, {36'h0, 36'hf_ffff_fffd}, 0, 1, 0, 1);
      rd_reg(OFS_STATUS, 32'ha);
      wr_reg(OFS_CFG, 32'h82);
      op_check(36, {36'h0, 36'h8_0000_0007}, {36'h0, 36'h8_0000_0009}, 1, 0, 1, 1);
      wr_reg(OFS_STATUS, 32'h2);
      rd_reg(OFS_STATUS, 32'h8);
      wr_reg(OFS_CFG, 32'h41d);
      @(posedge clk_sys);
      fab.set_chain(18'h2a5a5, 18'h15a5a);
      @(posedge clk_sys);
      fab.set_chain(18'h0, 18'h0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk_word({coa, cob[13:0]}, {18'h2a5a5, 14'h1a5a});
      @(posedge clk_sys);
      #1;
      chk_word({coa, cob[13:0]}, 32'h0);
      fab.set_ops('0, '0, 1'b0, 1'b0);
      wr_reg(OFS_CFG, 32'h12);
      rd_reg(OFS_STATUS, 32'h9);
      op_check(36, {36'h0, 36'h9_8765_4321}, {36'h0, 36'h3_0f0f_0f0f}, 0, 0, 0, 1);
      wr_reg(OFS_CFG, 32'h42);
      op_check(36, {36'h0, 36'h8_1234_5678}, {36'h0, 36'h0_9abc_def1}, 0, 0, 0, 2);
      wr_reg(OFS_CFG, 32'h810);
      @(posedge clk_sys);
      fab.set_chain(18'h2a5a5, 18'h15a5a);
      @(posedge clk_sys);
      fab.set_chain(18'h0, 18'h0);
      repeat (7) @(posedge clk_sys);
      #1;
      chk_word({14'h0, coa[17:9], cob[17:9]}, {14'h0, 9'h152, 9'h0ad});
      wrap_up();
   end
endmodule // tb

`default_nettype wire
